/* File: arith_pkg.sv */
/*
 * package for the dsp arithmetic unit status and condition block:
 * register offsets, status field positions, reset values, op codes.
 * assumes a classic wishbone slave with 32-bit data, word aligned.
 */
package arith_pkg;

    // ------------------------------------------------------------
    // register map (byte offsets)
    // ------------------------------------------------------------
    localparam logic [3:0] off_status = 4'h0;  // arith_status_control
    localparam logic [3:0] off_select = 4'h4;  // condition select field, bits 11:0
    localparam logic [3:0] off_cmd = 4'h8;     // instruction issue, write only
    localparam logic [3:0] off_acc = 4'hc;     // accumulator window, index in cmd

    // ------------------------------------------------------------
    // status field positions
    // ------------------------------------------------------------
    localparam int bit_test = 0;
    localparam int bit_carry = 1;
    localparam int bit_zero = 2;
    localparam int bit_neg = 3;
    localparam int bit_ovf = 5;
    localparam int bit_sovf = 6;
    localparam int bit_protect = 9;
    localparam int bit_xsd = 10;
    localparam int bit_me_lo = 12;
    localparam logic [15:0] status_mask = 16'hf66f;
    localparam logic [15:0] status_reset = 16'h0000;
    localparam logic [11:0] select_reset = 12'h000;

    // ------------------------------------------------------------
    // data width and saturation limits
    // ------------------------------------------------------------
    localparam int dw = 24;
    localparam logic [23:0] sat_pos = 24'h7fffff;
    localparam logic [23:0] sat_neg = 24'h800000;

    // ------------------------------------------------------------
    // instruction codes, cmd bits 4:0; acc index in 6:5; cond in 11:8
    // ------------------------------------------------------------
    localparam logic [4:0] op_nop = 5'h00;
    localparam logic [4:0] op_add = 5'h01;
    localparam logic [4:0] op_sub = 5'h02;
    localparam logic [4:0] op_addc = 5'h03;
    localparam logic [4:0] op_subc = 5'h04;
    localparam logic [4:0] op_inc = 5'h05;
    localparam logic [4:0] op_incc = 5'h06;
    localparam logic [4:0] op_neg = 5'h07;
    localparam logic [4:0] op_cmp = 5'h08;
    localparam logic [4:0] op_load = 5'h09;
    localparam logic [4:0] op_clear_load = 5'h0a;
    localparam logic [4:0] op_shl1 = 5'h0b;
    localparam logic [4:0] op_shr1 = 5'h0c;
    localparam logic [4:0] op_shl8 = 5'h0d;
    localparam logic [4:0] op_shr8 = 5'h0e;
    localparam logic [4:0] op_rlc = 5'h0f;
    localparam logic [4:0] op_rrc = 5'h10;
    localparam logic [4:0] op_test_t = 5'h11;
    localparam logic [4:0] op_test_ec3 = 5'h12;
    localparam logic [4:0] op_bit_reset = 5'h13;
    localparam logic [4:0] op_bit_set = 5'h14;
    localparam logic [4:0] op_shifter = 5'h15;
    localparam logic [4:0] op_exponent = 5'h16;
    localparam logic [4:0] op_add_t = 5'h17;
    localparam logic [4:0] op_sub_t = 5'h18;

    // ------------------------------------------------------------
    // condition codes
    // ------------------------------------------------------------
    localparam logic [3:0] cc_zero = 4'h0;
    localparam logic [3:0] cc_nzero = 4'h1;
    localparam logic [3:0] cc_carry = 4'h2;
    localparam logic [3:0] cc_ncarry = 4'h3;
    localparam logic [3:0] cc_neg = 4'h4;
    localparam logic [3:0] cc_pos = 4'h5;
    localparam logic [3:0] cc_ovf = 4'h6;
    localparam logic [3:0] cc_novf = 4'h7;
    localparam logic [3:0] cc_sovf = 4'h8;
    localparam logic [3:0] cc_test = 4'h9;
    localparam logic [3:0] cc_gt = 4'ha;
    localparam logic [3:0] cc_le = 4'hb;
    localparam logic [3:0] cc_true = 4'hf;

endpackage

/* File: cond_eval.sv */
/*
 * condition evaluator: picks one status bit or combination by a
 * 4-bit code. pure combinational, shared by test and condition outputs.
 */
`timescale 1ns/100ps
module cond_eval (
    // inputs
    input wire logic [3:0] code_i,
    input wire logic [15:0] status_i,
    // result
    output logic hit_o
);
    logic z, c, n, v;

    always_comb begin
        z = status_i[arith_pkg::bit_zero];
        c = status_i[arith_pkg::bit_carry];
        n = status_i[arith_pkg::bit_neg];
        v = status_i[arith_pkg::bit_ovf];
        unique case (code_i)
            arith_pkg::cc_zero: hit_o = z;  // RULE21
            arith_pkg::cc_nzero: hit_o = ~z;
            arith_pkg::cc_carry: hit_o = c;
            arith_pkg::cc_ncarry: hit_o = ~c;
            arith_pkg::cc_neg: hit_o = n;
            arith_pkg::cc_pos: hit_o = ~n;
            arith_pkg::cc_ovf: hit_o = v;
            arith_pkg::cc_novf: hit_o = ~v;
            arith_pkg::cc_sovf: hit_o = status_i[arith_pkg::bit_sovf];
            arith_pkg::cc_test: hit_o = status_i[arith_pkg::bit_test];
            arith_pkg::cc_gt: hit_o = ~z & ~n;
            arith_pkg::cc_le: hit_o = z | n;
            arith_pkg::cc_true: hit_o = 1'b1;
            default: hit_o = 1'b0;
        endcase
    end
endmodule

/* File: arith_status.sv */
/*
 * arithmetic unit status and condition block: four 24-bit accumulators,
 * arithmetic and single-cycle shift instructions, status register with
 * flags and control bits, four external condition outputs to the host.
 * assumes a wishbone classic master on clk_i; instructions arrive as
 * writes to the command register, one per bus cycle.
 */
`timescale 1ns/100ps
//
// Summary of operation
// (RULE1) conditional instructions act only when test flag is one, else change nothing
// (RULE2) test instruction aimed at test flag loads it with the chosen condition
// (RULE3) accumulator shifts take one cycle, right fills sign, left fills zero
// (RULE4) shifts use one accumulator in place, by 1 or 8, gated by test flag
// (RULE5) shift-through-carry variants move the carry flag in and out
// (RULE6) carry-suffixed instructions add the current carry for multi-precision chains
// (RULE7) lower three condition outputs follow their select field and flags
// (RULE8) fourth condition output changes only on a test instruction aimed at it
// (RULE9) host leaves one instruction gap before branching on a lower output at full speed
// (RULE10) slower hosts may branch right after the changing instruction
// (RULE11) modulo-enable bits choose modulo post-modify per pointer, clear on reset
// (RULE12) index-extend bit selects extension index and 8-bit steps, clears on reset
// (RULE13) overflow-protect bit saturates overflowing accumulator results, clears on reset
// (RULE14) shifter and exponent ops write shifter-overflow flag, not arithmetic overflow
// (RULE15) arithmetic overflow flag set when result does not fit 24 bits
// (RULE16) negative flag is result msb, inverted on overflow
// (RULE17) zero flag set when result is zero
// (RULE18) carry flag reflects carry out, untouched by load
// (RULE19) status writes may overwrite every flag directly
// (RULE20) bit reset and set instructions change single control bits
// (RULE21) select code zero routes zero flag to its condition output
// (RULE22) saturation limits are 7fffff and 800000, reads never saturate
// (RULE23) memory loads and clear-load leave flags alone
// (RULE24) flags and lower outputs update in the cycle the result is written
//
module arith_status (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // condition outputs to host
    output logic [3:0] external_condition_outputs_o,
    // control bits to address generation
    output logic [3:0] modulo_enable_bits_o,
    output logic index_extend_select_o
);
    logic [15:0] status_reg, status_next;
    logic [11:0] select_reg, select_next;
    logic [23:0] acc_reg [4];
    logic [23:0] acc_next [4];
    logic [1:0] acc_ptr_reg, acc_ptr_next;
    logic [3:0] ext_reg, ext_next;
    logic ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [3:0] sel_hit;
    logic test_hit, ec3_hit;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic bus_req, wr, rd;
    logic [31:0] cmd;
    logic [4:0] op;
    logic [1:0] ai, bi;
    logic [3:0] cc;
    logic [23:0] operand;

    assign bus_req = cyc_i & stb_i & ~ack_reg;
    assign wr = bus_req & we_i;
    assign rd = bus_req & ~we_i;
    assign cmd = dat_i;
    assign op = cmd[4:0];
    assign ai = cmd[6:5];
    assign bi = cmd[13:12];
    assign cc = cmd[11:8];
    assign operand = cmd[31:8];

    // ------------------------------------------------------------
    // condition evaluators: test operand and three select fields
    // ------------------------------------------------------------
    cond_eval u_test (
        .code_i(cc),
        .status_i(status_reg),
        .hit_o(test_hit)
    );
    assign ec3_hit = test_hit;

    // evaluated on next status so outputs move with the flags
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sel
            cond_eval u_sel (
                .code_i(select_next[4*g +: 4]),
                .status_i(status_next),
                .hit_o(sel_hit[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // datapath and status update
    // ------------------------------------------------------------
    logic [24:0] sum;
    logic [23:0] a, res;
    logic cin, cout, ovf, arith, flags, write_acc, t_ok;

    always_comb begin
        status_next = status_reg;
        select_next = select_reg;
        for (int i = 0; i < 4; i++) begin
            acc_next[i] = acc_reg[i];
        end
        acc_ptr_next = acc_ptr_reg;
        ext_next = ext_reg;
        a = acc_reg[ai];
        sum = 25'h0000000;
        res = a;
        cin = status_reg[arith_pkg::bit_carry];
        cout = 1'b0;
        ovf = 1'b0;
        arith = 1'b0;
        flags = 1'b0;
        write_acc = 1'b0;
        t_ok = status_reg[arith_pkg::bit_test];
        if (wr && adr_i == arith_pkg::off_status) begin
            // whole-register write overwrites every flag and control bit
            status_next = dat_i[15:0] & arith_pkg::status_mask;  // RULE19
        end else if (wr && adr_i == arith_pkg::off_select) begin
            select_next = dat_i[11:0];
        end else if (wr && adr_i == arith_pkg::off_acc) begin
            // direct accumulator write, flags untouched like a memory load
            acc_next[acc_ptr_reg] = dat_i[23:0];  // RULE23
        end else if (wr && adr_i == arith_pkg::off_cmd) begin
            acc_ptr_next = ai;
            unique case (op)
                arith_pkg::op_add, arith_pkg::op_add_t: begin
                    sum = {1'b0, a} + {1'b0, acc_reg[bi]};
                    arith = 1'b1;
                end
                arith_pkg::op_sub, arith_pkg::op_sub_t, arith_pkg::op_cmp: begin
                    sum = {1'b0, a} + {1'b0, ~acc_reg[bi]} + 25'h0000001;
                    arith = 1'b1;
                end
                arith_pkg::op_addc: begin
                    sum = {1'b0, a} + {1'b0, acc_reg[bi]} + {24'h000000, cin};  // RULE6
                    arith = 1'b1;
                end
                arith_pkg::op_subc: begin
                    sum = {1'b0, a} + {1'b0, ~acc_reg[bi]} + {24'h000000, cin};  // RULE6
                    arith = 1'b1;
                end
                arith_pkg::op_inc: begin
                    sum = {1'b0, a} + 25'h0000001;
                    arith = 1'b1;
                end
                arith_pkg::op_incc: begin
                    sum = {1'b0, a} + {24'h000000, cin};  // RULE6
                    arith = 1'b1;
                end
                arith_pkg::op_neg: begin
                    sum = {1'b0, ~a} + 25'h0000001;
                    arith = 1'b1;
                end
                arith_pkg::op_load, arith_pkg::op_clear_load: begin
                    acc_next[ai] = operand;  // RULE23
                end
                arith_pkg::op_shl1, arith_pkg::op_shr1, arith_pkg::op_shl8,
                arith_pkg::op_shr8, arith_pkg::op_rlc, arith_pkg::op_rrc: begin
                    if (t_ok) begin  // RULE4
                        flags = 1'b1;
                        write_acc = 1'b1;
                        unique case (op)  // RULE3
                            arith_pkg::op_shl1: begin
                                res = {a[22:0], 1'b0};
                                cout = a[23];
                            end
                            arith_pkg::op_shr1: begin
                                res = {a[23], a[23:1]};
                                cout = a[0];
                            end
                            arith_pkg::op_shl8: begin
                                res = {a[15:0], 8'h00};
                                cout = a[16];
                            end
                            arith_pkg::op_shr8: begin
                                res = {{8{a[23]}}, a[23:8]};
                                cout = a[7];
                            end
                            arith_pkg::op_rlc: begin
                                res = {a[22:0], cin};  // RULE5
                                cout = a[23];
                            end
                            default: begin
                                res = {cin, a[23:1]};  // RULE5
                                cout = a[0];
                            end
                        endcase
                        ovf = (op == arith_pkg::op_shl1 || op == arith_pkg::op_rlc)
                            ? (a[23] ^ a[22]) : 1'b0;
                    end
                end
                arith_pkg::op_test_t: begin
                    status_next[arith_pkg::bit_test] = test_hit;  // RULE2
                end
                arith_pkg::op_test_ec3: begin
                    ext_next[3] = ec3_hit;  // RULE8
                end
                arith_pkg::op_bit_reset, arith_pkg::op_bit_set: begin
                    // only control bits may be targeted this way
                    if (cmd[11:8] == 4'(arith_pkg::bit_protect)
                        || cmd[11:8] == 4'(arith_pkg::bit_xsd)
                        || cmd[11:8] >= 4'(arith_pkg::bit_me_lo)) begin
                        status_next[cmd[11:8]] = (op == arith_pkg::op_bit_set);  // RULE20
                    end
                end
                arith_pkg::op_shifter: begin
                    // shifter result handed in; flags only, overflow to its own flag
                    res = operand;
                    status_next[arith_pkg::bit_sovf] = cmd[5];  // RULE14
                    status_next[arith_pkg::bit_neg] = res[23] ^ cmd[5];
                    status_next[arith_pkg::bit_zero] = (res == 24'h000000);
                    status_next[arith_pkg::bit_carry] = cmd[6];
                end
                arith_pkg::op_exponent: begin
                    // all zeros or all ones source has no exponent
                    status_next[arith_pkg::bit_sovf] =
                        (a == 24'h000000) || (a == 24'hffffff);  // RULE14
                end
                default: begin
                end
            endcase
            if (arith) begin
                // suffix-t ops are gated by the test flag
                if ((op != arith_pkg::op_add_t && op != arith_pkg::op_sub_t) || t_ok) begin  // RULE1
                    res = sum[23:0];
                    cout = sum[24];
                    ovf = (op == arith_pkg::op_neg) ? (a == arith_pkg::sat_neg)
                        : (op == arith_pkg::op_inc || op == arith_pkg::op_incc)
                        ? (~a[23] & res[23])
                        : (op == arith_pkg::op_add || op == arith_pkg::op_add_t
                           || op == arith_pkg::op_addc)
                        ? ((a[23] == acc_reg[bi][23]) && (res[23] != a[23]))
                        : ((a[23] != acc_reg[bi][23]) && (res[23] != a[23]));
                    flags = 1'b1;
                    write_acc = (op != arith_pkg::op_cmp);
                end
            end
            if (flags) begin
                status_next[arith_pkg::bit_ovf] = ovf;  // RULE15
                status_next[arith_pkg::bit_neg] = res[23] ^ ovf;  // RULE16
                status_next[arith_pkg::bit_zero] = (res == 24'h000000);  // RULE17
                status_next[arith_pkg::bit_carry] = cout;  // RULE18
            end
            if (write_acc) begin
                if (ovf && status_reg[arith_pkg::bit_protect]) begin
                    // limit takes the sign of the source accumulator
                    acc_next[ai] = a[23] ? arith_pkg::sat_neg : arith_pkg::sat_pos;  // RULE13 RULE22
                end else begin
                    acc_next[ai] = res;
                end
            end
        end
        // lower outputs registered with the flags, so they move together
        ext_next[2:0] = sel_hit[2:0];  // RULE7 RULE24
    end

    // ------------------------------------------------------------
    // bus answer: one registered ack a cycle after the request, read data from current state
    // ------------------------------------------------------------
    always_comb begin
        ack_next = bus_req;
        rdata_next = 32'h00000000;
        if (rd) begin
            unique case (adr_i)
                arith_pkg::off_status: rdata_next = {16'h0000, status_reg};
                arith_pkg::off_select: rdata_next = {20'h00000, select_reg};
                // accumulator reads show the stored value, never saturated
                arith_pkg::off_acc: rdata_next = {8'h00, acc_reg[acc_ptr_reg]};  // RULE22
                default: rdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // control bits and flags clear on reset
            status_reg <= arith_pkg::status_reset;  // RULE11 RULE12 RULE13
            select_reg <= arith_pkg::select_reset;
            for (int i = 0; i < 4; i++) begin
                acc_reg[i] <= 24'h000000;
            end
            acc_ptr_reg <= 2'h0;
            ext_reg <= 4'h0;
            ack_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else begin
            status_reg <= status_next;
            select_reg <= select_next;
            for (int i = 0; i < 4; i++) begin
                acc_reg[i] <= acc_next[i];
            end
            acc_ptr_reg <= acc_ptr_next;
            ext_reg <= ext_next;
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign ack_o = ack_reg;
    assign dat_o = rdata_reg;
    assign external_condition_outputs_o = ext_reg;  // RULE9 RULE10
    assign modulo_enable_bits_o = status_reg[arith_pkg::bit_me_lo +: 4];  // RULE11
    assign index_extend_select_o = status_reg[arith_pkg::bit_xsd];  // RULE12
endmodule

/* File: arith_status_properties.sv */
/* checker for arith_status: bus answer, condition pins, control bits.
   assumes binding to arith_status, one clock, synchronous reset. */
`timescale 1ns/100ps
module arith_status_checker (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // pins
    input wire logic [3:0] external_condition_outputs_o,
    input wire logic [3:0] modulo_enable_bits_o,
    input wire logic index_extend_select_o
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing");
    AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
        else $error("ack too long");
    AST_EC3_HOLD: assert property ($changed(external_condition_outputs_o[3]) |->
        ack_o && $past(we_i && adr_i == arith_pkg::off_cmd)) else $error("pin 3 moved");
    AST_LOW_HOLD: assert property ($changed(external_condition_outputs_o[2:0]) |->
        ack_o && $past(we_i)) else $error("lower pins moved");
    AST_ME_HOLD: assert property ($changed(modulo_enable_bits_o) |->
        ack_o && $past(we_i)) else $error("modulo bits moved");
    AST_XSD_HOLD: assert property ($changed(index_extend_select_o) |->
        ack_o && $past(we_i)) else $error("extend bit moved");
    AST_CTRL_READ: assert property (ack_o && $past(!we_i && adr_i == arith_pkg::off_status)
        |-> dat_o[15:12] == modulo_enable_bits_o && dat_o[10] == index_extend_select_o)
        else $error("control bits differ");
    AST_RESET_CLEAR: assert property (disable iff (1'b0) rst_i |=>
        modulo_enable_bits_o == 4'h0 && !index_extend_select_o) else $error("reset bits");
    cover property ($rose(external_condition_outputs_o[3]));
    cover property ($changed(modulo_enable_bits_o));
    cover property (ack_o && $past(we_i && adr_i == arith_pkg::off_cmd));
endmodule
bind arith_status arith_status_checker u_arith_status_checker (.clk_i, .rst_i, .cyc_i,
    .stb_i, .we_i, .adr_i, .dat_o, .ack_o, .external_condition_outputs_o,
    .modulo_enable_bits_o, .index_extend_select_o);

/* File: host_branch_model.sv */
/* host side of the condition pins: samples them as a branch would.
   assumes the pins are registered on the same clock. */
`timescale 1ns/100ps
module host_branch_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // pins in, branch view out
    input wire logic [3:0] cond_i,
    output logic [3:0] seen_o
);
    // ----------------------------------------
    // branch sampling
    // ----------------------------------------
    logic [3:0] seen_reg;
    logic [3:0] seen_next;
    // full speed host branches one slot late, so one register sits between
    always_comb begin
        seen_next = cond_i;
    end
    always_ff @(posedge clk_i) begin
        seen_reg <= rst_i ? 4'h0 : seen_next;
    end
    assign seen_o = seen_reg;
endmodule

/* File: tb_top.sv */
/* testbench for arith_status: bus tasks and instruction sequences.
   assumes arith_pkg, the checker and the host model are compiled. */
`timescale 1ns/100ps
module tb_top;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [3:0] adr_i = 4'h0, sel_i = 4'hf, ext, me, seen;
    logic [31:0] dat_i = 32'h0, dat_o, rd, e;
    logic ack_o, index_extend_select;
    int err_count = 0, checks_done = 0, cycles = 0;
    int bl[6] = '{9, 10, 12, 13, 14, 15};
    localparam logic [3:0] st = arith_pkg::off_status, ac = arith_pkg::off_acc;
    arith_status u_arith_status (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
        .dat_i, .dat_o, .ack_o, .external_condition_outputs_o(ext),
        .modulo_enable_bits_o(me), .index_extend_select_o(index_extend_select));
    host_branch_model u_host_branch_model (.clk_i, .rst_i, .cond_i(ext), .seen_o(seen));
    always #50 clk_i = ~clk_i;
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            close_out();
        end
    end
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        checks_done++;
        if (g !== x) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, x, g);
        end
    endtask
    // only the low 24 bits carry data on every readable word
    task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] x);
        bus(1'b0, a, 32'h0);
        chk(nm, x, {8'h0, rd[23:0]});
    endtask
    task automatic op(input logic [4:0] o, input logic [1:0] a, input logic [3:0] c,
        input logic [1:0] b);
        bus(1'b1, arith_pkg::off_cmd, {18'h0, b, c, 1'b0, a, o});
    endtask
    task automatic ld(input logic [1:0] a, input logic [23:0] v);
        bus(1'b1, arith_pkg::off_cmd, {v, 1'b0, a, arith_pkg::op_load});
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc("status", st, 32'h0);
        chk("pins", 32'h0, {23'h0, me, index_extend_select, ext});
        bus(1'b1, st, 32'hffffffff);
        rdc("status", st, 32'hf66f);
        chk("ctrl", 32'h1f, {27'h0, me, index_extend_select});
        bus(1'b1, st, 32'h0);
        e = 32'h0;
        foreach (bl[i]) begin
            op(arith_pkg::op_bit_set, 2'h0, 4'(bl[i]), 2'h0);
            e[bl[i]] = 1'b1;
            rdc("bit set", st, e);
        end
        op(arith_pkg::op_bit_reset, 2'h0, 4'hc, 2'h0);
        rdc("bit reset", st, 32'he600);
        $display("test control done");
        bus(1'b1, st, 32'h0);
        ld(2'h0, 24'h800001);
        op(arith_pkg::op_shr1, 2'h0, 4'h0, 2'h0);
        rdc("gated", ac, 32'h800001);
        bus(1'b1, st, 32'h1);
        op(arith_pkg::op_shr1, 2'h0, 4'h0, 2'h0);
        rdc("shr1", ac, 32'hc00000);
        op(arith_pkg::op_shl8, 2'h0, 4'h0, 2'h0);
        rdc("shl8", ac, 32'h0);
        rdc("flags", st, 32'h5);
        ld(2'h1, 24'h800000);
        bus(1'b1, st, 32'h3);
        op(arith_pkg::op_rlc, 2'h1, 4'h0, 2'h0);
        rdc("rlc", ac, 32'h1);
        rdc("carry", st, 32'h2b);
        bus(1'b1, st, 32'h0);
        ld(2'h0, 24'h7fffff);
        ld(2'h1, 24'h000001);
        op(arith_pkg::op_add, 2'h0, 4'h0, 2'h1);
        rdc("wrap", ac, 32'h800000);
        rdc("status", st, 32'h20);
        bus(1'b1, st, 32'h200);
        ld(2'h0, 24'h7fffff);
        op(arith_pkg::op_add, 2'h0, 4'h0, 2'h1);
        rdc("sat", ac, 32'h7fffff);
        bus(1'b1, st, 32'h0);
        ld(2'h0, 24'hffffff);
        op(arith_pkg::op_add, 2'h0, 4'h0, 2'h1);
        rdc("status", st, 32'h6);
        ld(2'h2, 24'h000010);
        op(arith_pkg::op_clear_load, 2'h3, 4'h0, 2'h0);
        rdc("status", st, 32'h6);
        ld(2'h3, 24'h0);
        op(arith_pkg::op_addc, 2'h2, 4'h0, 2'h3);
        rdc("addc", ac, 32'h11);
        $display("test arithmetic done");
        bus(1'b1, st, 32'h4);
        bus(1'b1, arith_pkg::off_select, 32'h0);
        chk("lower", 32'h7, {29'h0, ext[2:0]});
        bus(1'b1, arith_pkg::off_select, 32'h10f);
        chk("lower", 32'h3, {29'h0, ext[2:0]});
        rdc("select", arith_pkg::off_select, 32'h10f);
        op(arith_pkg::op_test_ec3, 2'h0, arith_pkg::cc_zero, 2'h0);
        bus(1'b1, st, 32'h0);
        chk("pins", 32'hd, {28'h0, ext});
        @(posedge clk_i);
        chk("host", 32'hd, {28'h0, seen});
        op(arith_pkg::op_test_t, 2'h0, arith_pkg::cc_nzero, 2'h0);
        rdc("test flag", st, 32'h1);
        bus(1'b1, arith_pkg::off_cmd, {24'h800000, 3'h1, arith_pkg::op_shifter});
        rdc("shifter", st, 32'h41);
        ld(2'h0, 24'h400000);
        op(arith_pkg::op_exponent, 2'h0, 4'h0, 2'h0);
        rdc("exponent", st, 32'h1);
        bus(1'b1, st, 32'h0);
        op(arith_pkg::op_add_t, 2'h0, 4'h0, 2'h1);
        rdc("add t", ac, 32'h400000);
        bus(1'b1, st, 32'h1);
        op(arith_pkg::op_add_t, 2'h0, 4'h0, 2'h1);
        rdc("add t", ac, 32'h400001);
        rdc("unmapped", 4'h1, 32'h0);
        $display("test conditions done");
        close_out();
    end
endmodule
